/* hw/pcs_params.svh */
// offsets, field positions, reset values and fixed widths of the pcs block
`ifndef PCS_PARAMS_SVH
`define PCS_PARAMS_SVH

// -----------------------------------------------------------------
// register byte offsets
// -----------------------------------------------------------------
`define OFS_CTRL 8'h00
`define OFS_SYNC_CFG 8'h04
`define OFS_RUNLEN 8'h08
`define OFS_PATTERN 8'h0C
`define OFS_SYNC_STAT 8'h10
`define OFS_RL_STAT 8'h14

// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define CTRL_MODE_LSB 0
`define CTRL_ALIGN_BIT 4
`define CTRL_SLIP_BIT 5
`define CTRL_TXSLIP_LSB 8
`define CTRL_RL_EN_BIT 12
`define CFG_GOOD_LSB 0
`define CFG_BAD_LSB 8
`define CFG_PATS_LSB 16
`define PAT_LEN10_BIT 16

// -----------------------------------------------------------------
// reset values and fixed figures
// -----------------------------------------------------------------
`define CTRL_RST 32'h0000_0000
`define SYNC_CFG_RST 32'h0003_0404
`define RUNLEN_RST 32'h0000_00A0
`define PATTERN_RST 32'h0001_00FA
`define CODE_W 10
`define RUN_MAX 10'h3FF

`endif

/* hw/pcs_pkg.sv */
// types shared by the pcs coding and alignment block
package pcs_pkg;

  // -----------------------------------------------------------------
  // per-lane stream carriers
  // -----------------------------------------------------------------
  typedef struct packed {
    logic force_disp; // override encoder disparity
    logic disp_val; // 1 = positive disparity
    logic ctrl; // 1 = control symbol
    logic [7:0] data;
  } tx_lane_type;

  typedef struct packed {
    logic [7:0] data;
    logic ctrl; // 1 = control symbol
    logic disp; // running disparity, 1 = positive
    logic code_err; // not a legal code group
    logic disp_err; // legal code, wrong disparity
    logic sync; // aligner synchronised
    logic runlen_err; // run-length violation
  } rx_lane_type;

  // -----------------------------------------------------------------
  // modes and states
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_MANUAL = 2'b00,
    MODE_BITSLIP = 2'b01,
    MODE_AUTO = 2'b10
  } align_mode_type;

  typedef enum logic [1:0] {
    ST_LOSS = 2'b00,
    ST_ACQ = 2'b01,
    ST_SYNCED = 2'b10
  } sync_state_type;

endpackage : pcs_pkg

/* hw/pcs_code_align.sv */
// 8b/10b coding, word alignment and run-length check with wishbone control
`timescale 1ns/1ps
`include "pcs_params.svh"

module pcs_code_align
  import pcs_pkg::*;
#(
  parameter int LANES = 1,
  parameter bit PER_LANE = 1'b1,
  parameter int ALIGN_W = 10,
  parameter bit CODING_EN = 1'b1
)
(
  // clock and reset, one clock for every lane
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // transmit stream from mac and code groups to pma
  input wire tx_lane_type [LANES-1:0] tx_lane_i,
  output logic [LANES-1:0][9:0] tx_code_o,
  // raw receive words from pma and decoded stream to mac
  input wire logic [LANES-1:0][9:0] rx_raw_i,
  output rx_lane_type [LANES-1:0] rx_lane_o
);

  // -----------------------------------------------------------------
  // code tables, entry n at bits n*width, running disparity negative
  // -----------------------------------------------------------------
  localparam logic [191:0] TAB6 = {
    6'b101011, 6'b011110, 6'b101110, 6'b001110, 6'b110110, 6'b010110, 6'b100110, 6'b110011,
    6'b111010, 6'b011010, 6'b101010, 6'b001011, 6'b110010, 6'b010011, 6'b100011, 6'b011011,
    6'b010111, 6'b011100, 6'b101100, 6'b001101, 6'b110100, 6'b010101, 6'b100101, 6'b111001,
    6'b111000, 6'b011001, 6'b101001, 6'b110101, 6'b110001, 6'b101101, 6'b011101, 6'b100111};
  localparam logic [31:0] TAB4 = {
    4'b1110, 4'b0110, 4'b1010, 4'b1101, 4'b1100, 4'b0101, 4'b1001, 4'b1011};
  // automatic mode needs coded data at a 10 or 20 bit aligner
  localparam bit AUTO_OK = CODING_EN && (ALIGN_W == 10 || ALIGN_W == 20);

  // -----------------------------------------------------------------
  // functions
  // -----------------------------------------------------------------
  // encoder, returns {disparity after, abcdei fghj}
  function automatic logic [10:0] enc8b10b(input logic [7:0] d, input logic k, input logic rd);
    logic [5:0] s6;
    logic [3:0] s4;
    logic rdm;
    logic rdo;
    logic [4:0] x;
    logic [2:0] y;
    x = d[4:0];
    y = d[7:5];
    s6 = TAB6[6*x +: 6];
    if (k && x == 5'd28)
      s6 = 6'b001111;
    if (rd && ($countones(s6) != 3 || x == 5'd7))
      s6 = ~s6;
    rdm = ($countones(s6) == 3) ? rd : ($countones(s6) > 3);
    s4 = TAB4[4*y +: 4];
    // alternate x.7 avoids a run of five inside the code group
    if (y == 3'd7 && (k || (!rdm && (x == 5'd17 || x == 5'd18 || x == 5'd20))
        || (rdm && (x == 5'd11 || x == 5'd13 || x == 5'd14))))
      s4 = 4'b0111;
    if (rdm && ($countones(s4) != 2 || y == 3'd3))
      s4 = ~s4;
    else if (k && x == 5'd28 && !rdm && y != 3'd3 && $countones(s4) == 2)
      s4 = ~s4;
    rdo = ($countones(s4) == 2) ? rdm : ($countones(s4) > 2);
    return {rdo, s6, s4};
  endfunction : enc8b10b

  // decoder by search, returns {code_err, disp_err, k, data, disparity after}
  function automatic logic [11:0] dec8b10b(input logic [9:0] code, input logic rd);
    logic [11:0] res;
    logic [10:0] e;
    logic [8:0] v;
    logic found;
    logic kok;
    logic rdn;
    rdn = ($countones(code) > 5) ? 1'b1 : (($countones(code) < 5) ? 1'b0 : rd);
    res = {2'b10, 1'b0, 8'h00, rdn};
    found = 1'b0;
    for (int i = 0; i < 512; i++)
    begin
      v = i[8:0];
      kok = !v[8] || v[4:0] == 5'd28 || (v[7:5] == 3'd7 && (v[4:0] == 5'd23
        || v[4:0] == 5'd27 || v[4:0] == 5'd29 || v[4:0] == 5'd30));
      e = enc8b10b(v[7:0], v[8], rd);
      if (!found && kok && e[9:0] == code)
      begin
        found = 1'b1;
        res = {2'b00, v, e[10]};
      end
      e = enc8b10b(v[7:0], v[8], ~rd);
      if (!found && kok && e[9:0] == code)
      begin
        found = 1'b1;
        res = {2'b01, v, e[10]};
      end
    end
    return res;
  endfunction : dec8b10b

  // word at a bit offset of two words, oldest bit first
  function automatic logic [9:0] pick(input logic [19:0] h, input logic [3:0] o);
    return h[5'd19 - {1'b0, o} -: 10];
  endfunction : pick

  // identical bits at the newest end of a word
  function automatic logic [9:0] trail(input logic [9:0] w);
    logic [9:0] n;
    logic same;
    n = 10'h001;
    same = 1'b1;
    for (int i = 1; i < 10; i++)
    begin
      same = same && (w[i] == w[0]);
      if (same)
        n = n + 10'h001;
    end
    return n;
  endfunction : trail

  // -----------------------------------------------------------------
  // register file
  // -----------------------------------------------------------------
  logic [31:0] ctrl_ff; // mode, requests, tx slip, run-length enable
  logic [31:0] sync_cfg_ff; // good-run, bad-word and pattern counts
  logic [31:0] runlen_ff; // run-length threshold
  logic [31:0] pattern_ff; // alignment pattern and length
  logic ack_ff; // one-cycle answer
  logic [31:0] dat_ff; // read data
  logic [LANES-1:0] sync_vec; // per-lane sync status
  logic [LANES-1:0] rl_vec; // per-lane run-length flag
  logic align_d_ff; // last value of the align request bit
  logic slip_d_ff; // last value of the slip bit
  logic wr_stb; // accepted write
  logic align_rise; // new manual alignment request
  logic slip_rise; // new slip step
  align_mode_type mode_eff; // mode after the permission check

  // a write lands at the edge where the master samples ack high, not before
  assign wr_stb = cyc_i && stb_i && we_i && ack_ff;
  assign ack_o = ack_ff;
  assign dat_o = dat_ff;

  // byte-enable merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (sel[b])
        r[8*b +: 8] = nw[8*b +: 8];
    return r;
  endfunction : merge

  // answer every access one cycle after it starts, unmapped too
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_ff <= 1'b0;
    else
      ack_ff <= cyc_i && stb_i && !ack_ff;
  end

  // writable registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_ff <= `CTRL_RST;
      sync_cfg_ff <= `SYNC_CFG_RST;
      runlen_ff <= `RUNLEN_RST;
      pattern_ff <= `PATTERN_RST;
    end
    else if (wr_stb)
    begin
      if (adr_i == `OFS_CTRL)
        ctrl_ff <= merge(ctrl_ff, dat_i, sel_i);
      if (adr_i == `OFS_SYNC_CFG)
        sync_cfg_ff <= merge(sync_cfg_ff, dat_i, sel_i);
      if (adr_i == `OFS_RUNLEN)
        runlen_ff <= merge(runlen_ff, dat_i, sel_i);
      if (adr_i == `OFS_PATTERN)
        pattern_ff <= merge(pattern_ff, dat_i, sel_i);
    end
  end

  // read mux, unmapped and reserved bits read as zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_ff <= 32'h0000_0000;
    else if (cyc_i && stb_i && !we_i && !ack_ff)
      unique case (adr_i)
        `OFS_CTRL: dat_ff <= ctrl_ff & 32'h0000_1F33;
        `OFS_SYNC_CFG: dat_ff <= sync_cfg_ff & 32'h00FF_FFFF;
        `OFS_RUNLEN: dat_ff <= runlen_ff & 32'h0000_03FF;
        `OFS_PATTERN: dat_ff <= pattern_ff & 32'h0001_03FF;
        `OFS_SYNC_STAT: dat_ff <= 32'(sync_vec);
        `OFS_RL_STAT: dat_ff <= 32'(rl_vec);
        default: dat_ff <= 32'h0000_0000;
      endcase
  end

  // edge detect on the request bits; software writes 0 then 1 to repeat
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      align_d_ff <= 1'b0;
      slip_d_ff <= 1'b0;
    end
    else
    begin
      align_d_ff <= ctrl_ff[`CTRL_ALIGN_BIT];
      slip_d_ff <= ctrl_ff[`CTRL_SLIP_BIT];
    end
  end

  assign align_rise = ctrl_ff[`CTRL_ALIGN_BIT] && !align_d_ff;
  assign slip_rise = ctrl_ff[`CTRL_SLIP_BIT] && !slip_d_ff;

  // illegal mode codes and a forbidden automatic mode fall back to manual
  always_comb
  begin
    mode_eff = MODE_MANUAL;
    if (ctrl_ff[1:0] == MODE_BITSLIP)
      mode_eff = MODE_BITSLIP;
    else if (ctrl_ff[1:0] == MODE_AUTO && AUTO_OK)
      mode_eff = MODE_AUTO;
  end

  // -----------------------------------------------------------------
  // per-lane datapath, all lanes on clk_i so bonded lanes share it
  // -----------------------------------------------------------------
  for (genvar l = 0; l < LANES; l++)
  begin : g_lane
    // big-endian places lane 0 at the top of the bus, little-endian at the bottom
    localparam int P = PER_LANE ? LANES - 1 - l : l;
    logic [9:0] tx_cur_ff; // newest encoded word
    logic [9:0] tx_prev_ff; // word before it
    logic [9:0] tx_out_ff; // slipped word to the pma
    logic tx_rd_ff; // transmit running disparity
    logic [10:0] tx_enc; // encoder result
    logic [9:0] rx_prev_ff; // previous raw word
    logic [19:0] hist; // two words for the boundary search
    logic [9:0] win; // word at the current boundary
    logic [3:0] off_ff; // current boundary offset
    logic [11:0] dec; // decoder result
    logic rx_rd_ff; // receive running disparity
    logic armed_ff; // manual search pending
    logic found_ff; // pattern seen at this boundary
    sync_state_type st_ff; // automatic state
    logic [7:0] pat_cnt_ff; // patterns seen while acquiring
    logic [7:0] err_cnt_ff; // accumulated invalid words
    logic [7:0] good_cnt_ff; // valid words since last error step
    logic [9:0] run_ff; // current run of identical bits
    logic [9:0] run_nxt; // run after this word
    logic last_ff; // newest bit of the previous window
    logic hit_any; // some offset holds the pattern
    logic [3:0] hit_off; // lowest such offset
    logic win_hit; // pattern at current boundary
    rx_lane_type rx_ff; // registered stream to the mac

    // pattern compare, 10-bit or top 7 bits, either polarity
    function automatic logic pat_hit(input logic [9:0] w);
      if (pattern_ff[`PAT_LEN10_BIT])
        return w == pattern_ff[9:0] || w == ~pattern_ff[9:0];
      return w[9:3] == pattern_ff[9:3] || w[9:3] == ~pattern_ff[9:3];
    endfunction : pat_hit

    // transmit: forced disparity replaces the running value
    assign tx_enc = enc8b10b(tx_lane_i[P].data, tx_lane_i[P].ctrl,
      tx_lane_i[P].force_disp ? tx_lane_i[P].disp_val : tx_rd_ff);

    // transmit pipeline with boundary shift
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        tx_rd_ff <= 1'b0;
        tx_cur_ff <= 10'h000;
        tx_prev_ff <= 10'h000;
        tx_out_ff <= 10'h000;
      end
      else
      begin
        tx_rd_ff <= tx_enc[10];
        tx_cur_ff <= CODING_EN ? tx_enc[9:0] : {2'b00, tx_lane_i[P].data};
        tx_prev_ff <= tx_cur_ff;
        // offsets past nine are clipped so the window stays inside
        tx_out_ff <= pick({tx_prev_ff, tx_cur_ff}, (ctrl_ff[11:8] > 4'd9) ? 4'd9
          : ctrl_ff[11:8]);
      end
    end
    assign tx_code_o[P] = tx_out_ff;

    // receive word window and decode
    assign hist = {rx_prev_ff, rx_raw_i[P]};
    assign win = pick(hist, off_ff);
    assign dec = dec8b10b(win, rx_rd_ff);
    assign win_hit = pat_hit(win);

    // lowest offset that shows the pattern
    always_comb
    begin
      hit_any = 1'b0;
      hit_off = 4'd0;
      for (int o = 9; o >= 0; o--)
        if (pat_hit(pick(hist, 4'(o))))
        begin
          hit_any = 1'b1;
          hit_off = 4'(o);
        end
    end

    // boundary offset per mode
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
        off_ff <= 4'd0;
      else
        unique case (mode_eff)
          MODE_MANUAL: if (armed_ff && hit_any) off_ff <= hit_off;
          MODE_BITSLIP: if (slip_rise) off_ff <= (off_ff == 4'd9) ? 4'd0
            : off_ff + 4'd1;
          MODE_AUTO: if (st_ff == ST_LOSS && hit_any) off_ff <= hit_off;
          default: off_ff <= off_ff;
        endcase
    end

    // manual search flag, a new request wins over the clear
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
        armed_ff <= 1'b0;
      else if (align_rise)
        armed_ff <= 1'b1;
      else if (armed_ff && hit_any)
        armed_ff <= 1'b0;
    end

    // manual and slip sync: pattern seen at the chosen boundary
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
        found_ff <= 1'b0;
      else if (align_rise || slip_rise)
        found_ff <= 1'b0;
      else if ((armed_ff && hit_any && mode_eff == MODE_MANUAL) || win_hit)
        found_ff <= 1'b1;
    end

    // automatic synchronisation state machine
    always_ff @(posedge clk_i)
    begin
      if (rst_i || mode_eff != MODE_AUTO)
      begin
        st_ff <= ST_LOSS;
        pat_cnt_ff <= 8'd0;
        err_cnt_ff <= 8'd0;
        good_cnt_ff <= 8'd0;
      end
      else
        unique case (st_ff)
          ST_LOSS:
            if (hit_any)
            begin
              pat_cnt_ff <= 8'd1;
              // a count of zero or one is met by the first pattern
              st_ff <= (sync_cfg_ff[23:16] <= 8'd1) ? ST_SYNCED : ST_ACQ;
              err_cnt_ff <= 8'd0;
              good_cnt_ff <= 8'd0;
            end
          ST_ACQ:
            if (dec[11])
              st_ff <= ST_LOSS;
            else if (win_hit)
            begin
              pat_cnt_ff <= pat_cnt_ff + 8'd1;
              if ({1'b0, pat_cnt_ff} + 9'd1 >= {1'b0, sync_cfg_ff[23:16]})
                st_ff <= ST_SYNCED;
            end
          ST_SYNCED:
            if (dec[11])
            begin
              good_cnt_ff <= 8'd0;
              if (err_cnt_ff != 8'hFF)
                err_cnt_ff <= err_cnt_ff + 8'd1;
              if ({1'b0, err_cnt_ff} + 9'd1 >= {1'b0, sync_cfg_ff[15:8]})
                st_ff <= ST_LOSS;
            end
            else if ({1'b0, good_cnt_ff} + 9'd1 >= {1'b0, sync_cfg_ff[7:0]})
            begin
              good_cnt_ff <= 8'd0;
              if (err_cnt_ff != 8'd0)
                err_cnt_ff <= err_cnt_ff - 8'd1;
            end
            else
              good_cnt_ff <= good_cnt_ff + 8'd1;
          default: st_ff <= ST_LOSS;
        endcase
    end

    // run of identical bits, saturating
    always_comb
    begin
      run_nxt = trail(win);
      // a run only grows when the whole word repeats the previous window's last bit
      if (win == {10{last_ff}} && run_ff != 10'd0)
        run_nxt = (run_ff > `RUN_MAX - 10'd10) ? `RUN_MAX : run_ff + 10'd10;
    end

    // receive history, disparity and run counter
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        rx_prev_ff <= 10'h000;
        last_ff <= 1'b0;
        rx_rd_ff <= 1'b0;
        run_ff <= 10'd0;
      end
      else
      begin
        rx_prev_ff <= rx_raw_i[P];
        last_ff <= win[0];
        rx_rd_ff <= dec[0];
        run_ff <= run_nxt;
      end
    end

    // registered stream and status to the mac
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
        rx_ff <= '0;
      else
      begin
        rx_ff.data <= CODING_EN ? dec[8:1] : win[7:0];
        rx_ff.ctrl <= CODING_EN && dec[9];
        rx_ff.disp <= dec[0];
        rx_ff.code_err <= CODING_EN && dec[11];
        rx_ff.disp_err <= CODING_EN && dec[10];
        rx_ff.sync <= (mode_eff == MODE_AUTO) ? (st_ff == ST_SYNCED) : found_ff;
        rx_ff.runlen_err <= ctrl_ff[`CTRL_RL_EN_BIT] && (run_nxt > runlen_ff[9:0]);
      end
    end
    assign rx_lane_o[P] = rx_ff;
    assign sync_vec[l] = rx_ff.sync;
    assign rl_vec[l] = rx_ff.runlen_err;
  end

endmodule : pcs_code_align

/* tb/mac_model.sv */
// mac-side partner: sends bytes and remembers what is due back
`timescale 1ns/1ps
module mac_model
  import pcs_pkg::*;
#(
  parameter int LAG = 6
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // fixed word instead of random bytes
  input wire logic pin_en_i,
  input wire tx_lane_type pin_i,
  // stream out and expected echo
  output tx_lane_type tx_lane_o,
  output tx_lane_type exp_o
);
  tx_lane_type hist_ff [LAG]; // words in flight through the loop
  // new word right after each edge; random bytes are data only
  always_ff @(posedge clk_i)
  begin
    hist_ff[0] <= tx_lane_o;
    for (int i = 1; i < LAG; i++)
      hist_ff[i] <= hist_ff[i-1];
    if (rst_i)
      tx_lane_o <= '0;
    else if (pin_en_i)
      tx_lane_o <= pin_i;
    else
      tx_lane_o <= '{1'b0, 1'b0, 1'b0, 8'($urandom)};
  end
  assign exp_o = hist_ff[LAG-1];
endmodule : mac_model

/* tb/pcs_checker_sva.sv */
// assertion checker bound to the pcs coding and alignment block
`timescale 1ns/1ps
module pcs_checker
  import pcs_pkg::*;
#(
  parameter int LANES = 1
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // streams
  input wire tx_lane_type [LANES-1:0] tx_lane_i,
  input wire logic [LANES-1:0][9:0] tx_code_o,
  input wire rx_lane_type [LANES-1:0] rx_lane_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // edges since a forced disparity; forcing may break the pairing
  logic [2:0] quiet_ff;
  always_ff @(posedge clk_i)
  begin
    if (rst_i || tx_lane_i[0].force_disp)
      quiet_ff <= 3'h0;
    else if (quiet_ff != 3'h7)
      quiet_ff <= quiet_ff + 3'h1;
  end
  sequence req_s;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence rd_unmapped_s;
    req_s ##0 (!we_i && adr_i > 8'h14);
  endsequence
  property rst_clear_p;
    disable iff (1'b0) rst_i |=> !ack_o && tx_code_o == '0 && rx_lane_o == '0;
  endproperty
  property disp_pair_p;
    quiet_ff == 3'h7 && $past(tx_code_o[0]) != 10'h000 |->
      !(($countones(tx_code_o[0]) + $countones($past(tx_code_o[0]))) inside {8, 12});
  endproperty
  property sync_stat_p;
    ack_o && !$past(we_i) && $past(adr_i) == 8'h10 && $stable(rx_lane_o[0].sync)
      && $past(rx_lane_o[0].sync, 3) == rx_lane_o[0].sync |-> dat_o[0] == rx_lane_o[0].sync;
  endproperty
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack held too long");
  ack_answer_a: assert property (req_s |=> ack_o)
    else $error("ack late");
  ack_cause_a: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  reset_clear_a: assert property (rst_clear_p)
    else $error("outputs not cleared by reset");
  unmapped_zero_a: assert property (rd_unmapped_s |=> dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  code_weight_a: assert property (tx_code_o[0] != 10'h000 |->
    $countones(tx_code_o[0]) inside {4, 5, 6})
    else $error("code group weight illegal");
  disp_pair_a: assert property (disp_pair_p)
    else $error("running disparity broken");
  sync_stat_a: assert property (sync_stat_p)
    else $error("status disagrees with sync");
endmodule : pcs_checker
bind pcs_code_align pcs_checker #(.LANES(LANES)) chk (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o),
  .tx_lane_i(tx_lane_i), .tx_code_o(tx_code_o), .rx_lane_o(rx_lane_o));

/* tb/pcs_code_align_bench.sv */
// self-checking bench of the pcs block with a pma loop
`timescale 1ns/1ps
module pcs_code_align_bench
  import pcs_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0000_0000;
  logic [31:0] dat_o;
  logic ack_o;
  tx_lane_type [0:0] tx_lane;
  logic [0:0][9:0] tx_code;
  logic [0:0][9:0] rx_raw = '0;
  rx_lane_type [0:0] rx_lane;
  tx_lane_type pin = '0;
  tx_lane_type exp_w;
  logic pin_en = 1'b0;
  logic shift = 1'b0; // words arrive one bit late
  logic bad = 1'b0; // words arrive as all zeros
  logic [9:0] last_code = 10'h000;
  logic [31:0] q;
  int cnt;
  int failures = 0;
  int comparisons = 0;
  logic [7:0] reg_adr [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h20};
  logic [31:0] reg_rst [5] = '{32'h0000_0000, 32'h0003_0404, 32'h0000_00A0,
    32'h0001_00FA, 32'h0000_0000};
  initial
    forever #2 clk_i = ~clk_i;
  // pma stand-in: registered loop, optional slip or corruption
  always @(posedge clk_i)
  begin
    last_code <= tx_code[0];
    rx_raw[0] <= bad ? 10'h000 : (shift ? {last_code[0], tx_code[0][9:1]} : tx_code[0]);
  end
  pcs_code_align dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .tx_lane_i(tx_lane), .tx_code_o(tx_code), .rx_raw_i(rx_raw), .rx_lane_o(rx_lane));
  mac_model #(.LAG(6)) mac (.clk_i(clk_i), .rst_i(rst_i), .pin_en_i(pin_en), .pin_i(pin),
    .tx_lane_o(tx_lane[0]), .exp_o(exp_w));
  // code group of k28.5 or d0.0 in the chosen disparity column
  function automatic logic [9:0] forced_code(input logic k, input logic pos);
    if (k)
      return pos ? 10'h305 : 10'h0FA;
    return pos ? 10'h18B : 10'h274;
  endfunction : forced_code
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one classic cycle; held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    // no fixed latency assumed; only the watchdog ends a hung wait
    do
    begin
      @(posedge clk_i);
    end
    while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask : wb
  // request bits act on a rise, so write without then with
  task automatic pulse(input logic [31:0] base, input logic [31:0] req);
    wb(1'b1, 8'h00, base);
    wb(1'b1, 8'h00, base | req);
  endtask : pulse
  task automatic stream(input int n);
    repeat (n)
    begin
      @(posedge clk_i);
      #1;
      check(32'({rx_lane[0].data, rx_lane[0].ctrl, rx_lane[0].code_err, rx_lane[0].disp_err}),
        32'({exp_w.data, exp_w.ctrl, 2'b00}));
    end
  endtask : stream
  // counts code errors, or lost sync when sy is set
  task automatic scan(input logic sy, input int n);
    logic pd;
    pd = 1'bx;
    repeat (n)
    begin
      @(posedge clk_i);
      #1;
      if (sy ? rx_lane[0].sync !== 1'b1 : rx_lane[0].code_err !== 1'b0)
        cnt++;
      // k28.5 is unbalanced, so the running disparity must flip every word
      if (!sy && rx_lane[0].disp === pd)
        cnt++;
      pd = rx_lane[0].disp;
    end
  endtask : scan
  task automatic hit(input int n);
    @(posedge clk_i);
    bad <= 1'b1;
    repeat (n) @(posedge clk_i);
    bad <= 1'b0;
  endtask : hit
  task automatic print_verdict();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  // watchdog against a hung handshake
  initial
  begin
    repeat (30000) @(posedge clk_i);
    failures++;
    print_verdict();
  end
  initial
  begin
    void'($urandom(32'hc2b0));
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b1, 8'h20, 32'hFFFF_FFFF);
    foreach (reg_adr[i])
    begin
      wb(1'b0, reg_adr[i], 32'h0000_0000);
      check(q, reg_rst[i]);
    end
    stream(200);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk_i);
      pin <= '{1'b1, i[0], i[1], i[1] ? 8'hBC : 8'h00};
      pin_en <= 1'b1;
      repeat (6) @(posedge clk_i);
      #1;
      check(32'(tx_code[0]), 32'(forced_code(i[1], i[0])));
    end
    pin <= '{1'b0, 1'b0, 1'b1, 8'hBC};
    shift <= 1'b1;
    pulse(32'h0000_0000, 32'h0000_0010);
    repeat (30) @(posedge clk_i);
    wb(1'b0, 8'h10, 32'h0000_0000);
    check(q, 32'h0000_0001);
    shift <= 1'b0;
    cnt = 0;
    scan(1'b0, 40);
    check(32'(cnt != 0), 32'h0000_0001);
    // 7-bit compare from here on; the comma still marks only the true boundary
    wb(1'b1, 8'h0C, 32'h0000_00FA);
    pulse(32'h0000_0000, 32'h0000_0010);
    repeat (30) @(posedge clk_i);
    cnt = 0;
    scan(1'b0, 20);
    check(32'(cnt), 32'h0000_0000);
    pulse(32'h0000_0001, 32'h0000_0020);
    repeat (10) @(posedge clk_i);
    wb(1'b0, 8'h10, 32'h0000_0000);
    check(q, 32'h0000_0000);
    repeat (9) pulse(32'h0000_0001, 32'h0000_0020);
    repeat (10) @(posedge clk_i);
    wb(1'b0, 8'h10, 32'h0000_0000);
    check(q, 32'h0000_0001);
    pin_en <= 1'b0;
    repeat (10) @(posedge clk_i);
    stream(50);
    pin_en <= 1'b1;
    wb(1'b1, 8'h04, 32'h0003_0204);
    wb(1'b1, 8'h00, 32'h0000_0002);
    repeat (40) @(posedge clk_i);
    wb(1'b0, 8'h10, 32'h0000_0000);
    check(q, 32'h0000_0001);
    cnt = 0;
    hit(1);
    scan(1'b1, 12);
    hit(1);
    scan(1'b1, 12);
    check(32'(cnt), 32'h0000_0000);
    hit(2);
    scan(1'b1, 12);
    check(32'(cnt != 0), 32'h0000_0001);
    wb(1'b1, 8'h08, 32'h0000_0028);
    wb(1'b1, 8'h00, 32'h0000_1000);
    bad <= 1'b1;
    repeat (8) @(posedge clk_i);
    wb(1'b0, 8'h14, 32'h0000_0000);
    check(q, 32'h0000_0001);
    bad <= 1'b0;
    repeat (10) @(posedge clk_i);
    wb(1'b0, 8'h14, 32'h0000_0000);
    check(q, 32'h0000_0000);
    print_verdict();
  end
endmodule : pcs_code_align_bench
